// ---- design/ram_debug_readout.sv ----
// debug read-out of the core's internal instruction-side arrays
`timescale 1ns/100ps
`default_nettype none
`include "ram_debug_params.svh"

module ram_debug_readout (
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     sys_rst_i,
    // system register access
    input  wire logic [1:0]               priv_level_i,
    input  wire ram_debug_pkg::sreg_req_t sreg_req_i,
    output logic                          sreg_ready_o,
    output var  ram_debug_pkg::sreg_rsp_t sreg_rsp_o,
    // internal array port
    output var  ram_debug_pkg::ram_req_t  ram_req_o,
    input  wire ram_debug_pkg::ram_rsp_t  ram_rsp_i
);
    import ram_debug_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t      state_reg;
    state_t      state_next;
    logic [31:0] sel_reg;
    logic [31:0] sel_next;
    readout_t    iword_reg;
    readout_t    iword_next;
    readout_t    dword_reg;
    readout_t    dword_next;
    sreg_rsp_t   rsp_reg;
    sreg_rsp_t   rsp_next;
    readout_t    fmt_words;

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    wire logic       idle      = state_reg == ST_IDLE;
    wire logic       take      = sreg_req_i.valid & idle;
    wire logic       priv_ok   = priv_level_i == `TOP_PRIV;
    wire logic       legal     = take & priv_ok;
    wire logic       refuse    = take & ~priv_ok;
    wire logic       is_select = sreg_req_i.op == OP_SELECT;
    wire logic       do_select = legal & is_select;
    wire logic       do_read   = legal & ~is_select;
    wire logic [7:0] new_id    = sreg_req_i.wdata[`SEL_ID_HI:`SEL_ID_LO];
    // ids above the macro-op cache are not served here
    wire logic       new_known = new_id <= `ID_MOP;
    wire logic       start     = do_select & new_known;
    wire logic       capture   = (state_reg == ST_FETCH) & ram_rsp_i.valid;

    // ------------------------------------------------------------
    // location decode from the held select value
    // ------------------------------------------------------------
    wire logic [7:0]  sel_id   = sel_reg[`SEL_ID_HI:`SEL_ID_LO];
    wire logic        has_way  = (sel_id == `ID_ITAG) | (sel_id == `ID_IDATA);
    wire logic [1:0]  sel_way  = has_way ? sel_reg[`SEL_WAY_HI:`SEL_WAY_LO] : 2'h0;
    wire logic [10:0] idx_tag  = {3'h0, sel_reg[`IDX_TAG_HI:`IDX_TAG_LO]};
    wire logic [10:0] idx_dat  = sel_reg[`IDX_DATA_HI:`IDX_DATA_LO];
    wire logic [10:0] idx_btb  = sel_reg[`IDX_BTB_HI:`IDX_BTB_LO];
    wire logic [10:0] idx_ghb  = {2'h0, sel_reg[`IDX_GHB_HI:`IDX_GHB_LO]};
    wire logic [10:0] idx_bim  = {2'h0, sel_reg[`IDX_BIM_HI:`IDX_BIM_LO]};
    wire logic [10:0] idx_tlb  = {3'h0, sel_reg[`IDX_TLB_HI:`IDX_TLB_LO]};
    wire logic [10:0] idx_mop  = {1'h0, sel_reg[`IDX_MOP_HI:`IDX_MOP_LO]};
    wire logic [10:0] sel_idx  = (sel_id == `ID_ITAG)  ? idx_tag :
                                 (sel_id == `ID_IDATA) ? idx_dat :
                                 (sel_id == `ID_BTB)   ? idx_btb :
                                 (sel_id == `ID_GHB)   ? idx_ghb :
                                 (sel_id == `ID_BIM)   ? idx_bim :
                                 (sel_id == `ID_ITLB)  ? idx_tlb : idx_mop;

    assign ram_req_o.valid = state_reg == ST_FETCH;
    assign ram_req_o.id    = sel_id;
    assign ram_req_o.way   = sel_way;
    assign ram_req_o.index = sel_idx;

    // ------------------------------------------------------------
    // formatting of the raw entry
    // ------------------------------------------------------------
    readout_formatter u_fmt (
        .ram_id_i (sel_id),
        .raw_i    (ram_rsp_i.raw),
        .words_o  (fmt_words)
    );

    // ------------------------------------------------------------
    // read data mux
    // ------------------------------------------------------------
    wire logic [63:0] rd_word = (sreg_req_i.op == OP_RD_I0) ? iword_reg.w0 :
                                (sreg_req_i.op == OP_RD_I1) ? iword_reg.w1 :
                                (sreg_req_i.op == OP_RD_I2) ? iword_reg.w2 :
                                (sreg_req_i.op == OP_RD_D0) ? dword_reg.w0 :
                                (sreg_req_i.op == OP_RD_D1) ? dword_reg.w1 :
                                (sreg_req_i.op == OP_RD_D2) ? dword_reg.w2 : `WORD_RST;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        sel_next   = sel_reg;
        iword_next = iword_reg;
        dword_next = dword_reg;
        rsp_next   = '0;
        case (state_reg)
            ST_IDLE: begin
                if (refuse) begin
                    rsp_next.done  = 1'b1;
                    rsp_next.undef = 1'b1;
                end else if (do_read) begin
                    rsp_next.done  = 1'b1;
                    rsp_next.rdata = rd_word;
                end else if (do_select) begin
                    sel_next = sreg_req_i.wdata;
                    if (new_known) begin
                        state_next = ST_FETCH;
                    end else begin
                        // unserved ids leave nothing stale behind
                        iword_next    = '0;
                        dword_next    = '0;
                        rsp_next.done = 1'b1;
                    end
                end
            end
            ST_FETCH: begin
                if (capture) begin
                    // raw bits only, no correction on this path
                    iword_next    = fmt_words;
                    dword_next    = '0;
                    rsp_next.done = 1'b1;
                    state_next    = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
            sel_reg   <= `SEL_RST;
            iword_reg <= '0;
            dword_reg <= '0;
            rsp_reg   <= '0;
        end else begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            iword_reg <= iword_next;
            dword_reg <= dword_next;
            rsp_reg   <= rsp_next;
        end
    end

    // select of a served id retires only once the read-outs hold the new entry
    assign sreg_ready_o = idle;
    assign sreg_rsp_o   = rsp_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_refuse_undef;
        @(posedge clk_i) disable iff (sys_rst_i)
        refuse |=> sreg_rsp_o.undef && sreg_rsp_o.done && sreg_rsp_o.rdata == 64'h0;
    endproperty
    a_refuse_undef: assert property (p_refuse_undef)
        else $error("refused access did not raise undefined");

    property p_refuse_no_effect;
        @(posedge clk_i) disable iff (sys_rst_i)
        refuse |=> $stable(sel_reg) && state_reg == ST_IDLE && $stable(iword_reg);
    endproperty
    a_refuse_no_effect: assert property (p_refuse_no_effect)
        else $error("access below top privilege changed state");

    property p_legal_no_undef;
        @(posedge clk_i) disable iff (sys_rst_i)
        legal |=> !sreg_rsp_o.undef;
    endproperty
    a_legal_no_undef: assert property (p_legal_no_undef)
        else $error("top privilege access flagged undefined");

    property p_read_answer;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_read && sreg_req_i.op == OP_RD_I1
        |=> sreg_rsp_o.done && sreg_rsp_o.rdata == $past(iword_reg.w1);
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read-out word 1 answered wrongly");

    property p_select_fetch;
        @(posedge clk_i) disable iff (sys_rst_i)
        start |=> ram_req_o.valid && ram_req_o.id == $past(new_id);
    endproperty
    a_select_fetch: assert property (p_select_fetch)
        else $error("select did not fetch the named array");

    property p_tag_loc;
        @(posedge clk_i) disable iff (sys_rst_i)
        ram_req_o.valid && sel_id == `ID_ITAG
        |-> ram_req_o.way == sel_reg[19:18] && ram_req_o.index == {3'h0, sel_reg[13:6]};
    endproperty
    a_tag_loc: assert property (p_tag_loc)
        else $error("tag location decoded wrongly");

    property p_btb_loc;
        @(posedge clk_i) disable iff (sys_rst_i)
        ram_req_o.valid && sel_id == `ID_BTB
        |-> ram_req_o.way == 2'h0 && ram_req_o.index == sel_reg[14:4];
    endproperty
    a_btb_loc: assert property (p_btb_loc)
        else $error("btb location decoded wrongly");

    property p_raw_capture;
        @(posedge clk_i) disable iff (sys_rst_i)
        capture && sel_id == `ID_GHB
        |=> iword_reg.w0 == $past(ram_rsp_i.raw[63:0])
            && iword_reg.w1 == $past(ram_rsp_i.raw[127:64]) && iword_reg.w2 == 64'h0;
    endproperty
    a_raw_capture: assert property (p_raw_capture)
        else $error("history read-out altered raw data");

    property p_tlb_word1;
        @(posedge clk_i) disable iff (sys_rst_i)
        capture && sel_id == `ID_ITLB
        |=> iword_reg.w1[63:61] == 3'h0 && iword_reg.w1[60:0] == $past(ram_rsp_i.raw[124:64]);
    endproperty
    a_tlb_word1: assert property (p_tlb_word1)
        else $error("tlb word 1 packed wrongly");

    property p_hold_stable;
        @(posedge clk_i) disable iff (sys_rst_i)
        idle && !do_select |=> $stable(iword_reg) && $stable(dword_reg);
    endproperty
    a_hold_stable: assert property (p_hold_stable)
        else $error("read-outs changed without a select");

    property p_select_done;
        @(posedge clk_i) disable iff (sys_rst_i)
        capture |=> sreg_rsp_o.done ##1 (!sreg_rsp_o.done || $past(take));
    endproperty
    a_select_done: assert property (p_select_done)
        else $error("select completion not a single pulse");

    property p_dat_loc;
        @(posedge clk_i) disable iff (sys_rst_i)
        ram_req_o.valid && sel_id == `ID_IDATA
        |-> ram_req_o.way == sel_reg[19:18] && ram_req_o.index == sel_reg[13:3];
    endproperty
    a_dat_loc: assert property (p_dat_loc)
        else $error("instruction data location decoded wrongly");

    property p_tlb_loc;
        @(posedge clk_i) disable iff (sys_rst_i)
        ram_req_o.valid && sel_id == `ID_ITLB
        |-> ram_req_o.way == 2'h0 && ram_req_o.index == {3'h0, sel_reg[7:0]};
    endproperty
    a_tlb_loc: assert property (p_tlb_loc)
        else $error("tlb entry decoded wrongly");

    property p_bim_word;
        @(posedge clk_i) disable iff (sys_rst_i)
        capture && sel_id == `ID_BIM
        |=> iword_reg.w0 == {48'h0, $past(ram_rsp_i.raw[15:0])} && iword_reg.w1 == 64'h0;
    endproperty
    a_bim_word: assert property (p_bim_word)
        else $error("indirect map read-out packed wrongly");

    property p_unknown_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        do_select && !new_known
        |=> sreg_rsp_o.done && !ram_req_o.valid && iword_reg == '0 && dword_reg == '0;
    endproperty
    a_unknown_clear: assert property (p_unknown_clear)
        else $error("unserved id left stale read-outs");

    property p_fetch_hold;
        @(posedge clk_i) disable iff (sys_rst_i)
        ram_req_o.valid && !ram_rsp_i.valid
        |=> ram_req_o.valid && $stable(ram_req_o) && !sreg_ready_o;
    endproperty
    a_fetch_hold: assert property (p_fetch_hold)
        else $error("array request dropped before its answer");

endmodule : ram_debug_readout
`default_nettype wire

// ---- design/ram_debug_params.svh ----
// offsets, field positions and codes for the internal array read-out block
`ifndef RAM_DEBUG_PARAMS_SVH
`define RAM_DEBUG_PARAMS_SVH

// ------------------------------------------------------------
// privilege
// ------------------------------------------------------------
`define TOP_PRIV        2'h3

// ------------------------------------------------------------
// select value fields
// ------------------------------------------------------------
`define SEL_ID_HI       31
`define SEL_ID_LO       24
`define SEL_WAY_HI      19
`define SEL_WAY_LO      18
`define IDX_TAG_HI      13
`define IDX_TAG_LO      6
`define IDX_DATA_HI     13
`define IDX_DATA_LO     3
`define IDX_BTB_HI      14
`define IDX_BTB_LO      4
`define IDX_GHB_HI      13
`define IDX_GHB_LO      5
`define IDX_BIM_HI      12
`define IDX_BIM_LO      4
`define IDX_TLB_HI      7
`define IDX_TLB_LO      0
`define IDX_MOP_HI      9
`define IDX_MOP_LO      0

// ------------------------------------------------------------
// ram identifiers
// ------------------------------------------------------------
`define ID_ITAG         8'h00
`define ID_IDATA        8'h01
`define ID_BTB          8'h02
`define ID_GHB          8'h03
`define ID_ITLB         8'h04
`define ID_BIM          8'h05
`define ID_MOP          8'h06

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SEL_RST         32'h0000_0000
`define WORD_RST        64'h0000_0000_0000_0000

`endif

// ---- design/ram_debug_pkg.sv ----
// types shared by the internal array read-out block
package ram_debug_pkg;

    // ------------------------------------------------------------
    // system register operations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_SELECT = 3'b000,
        OP_RD_I0  = 3'b001,
        OP_RD_I1  = 3'b010,
        OP_RD_I2  = 3'b011,
        OP_RD_D0  = 3'b100,
        OP_RD_D1  = 3'b101,
        OP_RD_D2  = 3'b110
    } sreg_op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01
    } state_t;

    // tlb memory attribute codes, strictest device first
    typedef enum logic [2:0] {
        MA_DEV_NGNRNE = 3'b000,
        MA_DEV_NGNRE  = 3'b001,
        MA_DEV_NGRE   = 3'b010,
        MA_DEV_GRE    = 3'b011,
        MA_NONCACHE   = 3'b100,
        MA_WB_NOALLOC = 3'b101,
        MA_WB_TRANS   = 3'b110,
        MA_WB_RWALLOC = 3'b111
    } mem_attr_t;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        sreg_op_t    op;
        logic [31:0] wdata;
    } sreg_req_t;

    typedef struct packed {
        logic        done;
        logic        undef;
        logic [63:0] rdata;
    } sreg_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  id;
        logic [1:0]  way;
        logic [10:0] index;
    } ram_req_t;

    typedef struct packed {
        logic         valid;
        logic [127:0] raw;
    } ram_rsp_t;

    typedef struct packed {
        logic [63:0] w2;
        logic [63:0] w1;
        logic [63:0] w0;
    } readout_t;

endpackage : ram_debug_pkg

// ---- design/readout_formatter.sv ----
// packs raw array contents into the three instruction-side read-out words
`timescale 1ns/100ps
`default_nettype none
`include "ram_debug_params.svh"

module readout_formatter (
    // selection and raw entry
    input  wire logic [7:0]             ram_id_i,
    input  wire logic [127:0]           raw_i,
    // packed words
    output var ram_debug_pkg::readout_t words_o
);
    import ram_debug_pkg::*;

    // ------------------------------------------------------------
    // per-array layouts, raw bits pass untouched
    // ------------------------------------------------------------
    wire logic [63:0] tag_w0  = {32'h0, raw_i[31:0]};
    wire logic [63:0] dat_w1  = {55'h0, raw_i[72], raw_i[71:64]};
    wire logic [63:0] btb_w1  = {34'h0, raw_i[93:64]};
    wire logic [63:0] ghb_w1  = raw_i[127:64];
    wire logic [63:0] bim_w0  = {48'h0, raw_i[15:0]};
    // tlb word 0 fields already sit at their read-out positions
    wire logic [63:0] tlb_w0  = raw_i[63:0];
    wire logic [63:0] tlb_w1  = {3'h0, raw_i[124:64]};
    wire logic [63:0] mop_w1  = {30'h0, raw_i[97:64]};

    wire logic is_tag  = ram_id_i == `ID_ITAG;
    wire logic is_dat  = ram_id_i == `ID_IDATA;
    wire logic is_btb  = ram_id_i == `ID_BTB;
    wire logic is_ghb  = ram_id_i == `ID_GHB;
    wire logic is_tlb  = ram_id_i == `ID_ITLB;
    wire logic is_bim  = ram_id_i == `ID_BIM;
    wire logic is_mop  = ram_id_i == `ID_MOP;
    wire logic is_wide = is_dat | is_btb | is_ghb | is_mop;

    // ------------------------------------------------------------
    // selection
    // ------------------------------------------------------------
    assign words_o.w0 = is_tag  ? tag_w0 :
                        is_bim  ? bim_w0 :
                        is_tlb  ? tlb_w0 :
                        is_wide ? raw_i[63:0] : `WORD_RST;
    assign words_o.w1 = is_dat ? dat_w1 :
                        is_btb ? btb_w1 :
                        is_ghb ? ghb_w1 :
                        is_tlb ? tlb_w1 :
                        is_mop ? mop_w1 : `WORD_RST;
    // no instruction-side array uses the third word
    assign words_o.w2 = `WORD_RST;

endmodule : readout_formatter
`default_nettype wire

// ---- dv/test_ram_debug_readout.sv ----
// self-checking bench for the internal array read-out block
`timescale 1ns/100ps
`default_nettype none
`include "ram_debug_params.svh"

module test_ram_debug_readout;
    import ram_debug_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk_i;
    logic        sys_rst_i;
    logic [1:0]  priv_level_i;
    sreg_req_t   sreg_req_i;
    logic        sreg_ready_o;
    sreg_rsp_t   sreg_rsp_o;
    ram_req_t    ram_req_o;
    ram_rsp_t    ram_rsp_i;
    integer      seed = 32'h22008b32;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;

    ram_debug_readout DUT (
        .clk_i        (clk_i),
        .sys_rst_i    (sys_rst_i),
        .priv_level_i (priv_level_i),
        .sreg_req_i   (sreg_req_i),
        .sreg_ready_o (sreg_ready_o),
        .sreg_rsp_o   (sreg_rsp_o),
        .ram_req_o    (ram_req_o),
        .ram_rsp_i    (ram_rsp_i)
    );

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // hang guard: whole run needs under two thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic readout_t exp_words(input logic [7:0] id, input logic [127:0] r);
        readout_t w;
        w = '0;
        case (id)
            8'h00: w.w0 = {32'h0, r[31:0]};
            8'h01: begin w.w0 = r[63:0]; w.w1 = {55'h0, r[72:64]}; end
            8'h02: begin w.w0 = r[63:0]; w.w1 = {34'h0, r[93:64]}; end
            8'h03: begin w.w0 = r[63:0]; w.w1 = r[127:64]; end
            8'h04: begin w.w0 = r[63:0]; w.w1 = {3'h0, r[124:64]}; end
            8'h05: w.w0 = {48'h0, r[15:0]};
            8'h06: begin w.w0 = r[63:0]; w.w1 = {30'h0, r[97:64]}; end
            default: w = '0;
        endcase
        return w;
    endfunction : exp_words

    function automatic logic [10:0] exp_index(input logic [31:0] s);
        case (s[31:24])
            8'h00: return {3'h0, s[13:6]};
            8'h01: return s[13:3];
            8'h02: return s[14:4];
            8'h03: return {2'h0, s[13:5]};
            8'h04: return {3'h0, s[7:0]};
            8'h05: return {2'h0, s[12:4]};
            8'h06: return {1'h0, s[9:0]};
            default: return 11'h0;
        endcase
    endfunction : exp_index

    // ------------------------------------------------------------
    // one register access; bench also answers the array port
    // ------------------------------------------------------------
    task automatic access(input sreg_op_t op, input logic [31:0] wd, input logic [1:0] pl,
                          input logic [127:0] raw, input int dly,
                          output logic [63:0] rd, output logic und);
        int   n;
        logic served;
        logic fetch_exp;
        served = 1'b0;
        fetch_exp = (op == OP_SELECT) && (pl == `TOP_PRIV) && (wd[31:24] <= 8'h06);
        @(posedge clk_i);
        #1;
        priv_level_i     = pl;
        sreg_req_i.valid = 1'b1;
        sreg_req_i.op    = op;
        sreg_req_i.wdata = wd;
        n = 0;
        @(negedge clk_i);
        while (sreg_ready_o !== 1'b1 && n < 50) begin
            n++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
        #1;
        sreg_req_i.valid = 1'b0;
        sreg_req_i.wdata = $random(seed);
        rd = '0;
        und = 1'b0;
        n = 0;
        while (sreg_rsp_o.done !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
            if (ram_req_o.valid === 1'b1 && served !== 1'b1) begin
                served = 1'b1;
                check("ram id", 64'(ram_req_o.id), 64'(wd[31:24]));
                check("ram way", 64'(ram_req_o.way), (wd[31:24] < 8'h02) ? 64'(wd[19:18]) : 64'h0);
                check("ram index", 64'(ram_req_o.index), 64'(exp_index(wd)));
                check("ready in fetch", 64'(sreg_ready_o), 64'h0);
                repeat (dly) @(negedge clk_i);
                @(posedge clk_i);
                #1;
                ram_rsp_i.valid = 1'b1;
                // error detection taken as off, entries handed over unchanged
                ram_rsp_i.raw   = raw;
                @(posedge clk_i);
                #1;
                ram_rsp_i.valid = 1'b0;
                ram_rsp_i.raw   = ~raw;
            end
        end
        check("done seen", 64'(sreg_rsp_o.done), 64'h1);
        check("array read", 64'(served), 64'(fetch_exp));
        // done is launched by the take edge itself, so no cycle is waited
        if (op != OP_SELECT) check("read latency", 64'(n), 64'h0);
        rd  = sreg_rsp_o.rdata;
        und = sreg_rsp_o.undef;
    endtask : access

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [63:0]  rd;
        logic         und;
        readout_t     ew;
        logic [31:0]  sel;
        logic [127:0] raw;
        logic [7:0]   id;
        sys_rst_i    = 1'b1;
        priv_level_i = `TOP_PRIV;
        sreg_req_i   = '0;
        ram_rsp_i    = '0;
        repeat (4) @(posedge clk_i);
        #1;
        sys_rst_i = 1'b0;
        check("reset ready", 64'(sreg_ready_o), 64'h1);
        check("reset done", 64'(sreg_rsp_o.done), 64'h0);
        check("reset fetch", 64'(ram_req_o.valid), 64'h0);
        for (int i = 0; i < 9; i++) begin
            for (int k = 0; k < 8; k++) begin
                id  = (i < 7) ? 8'(i) : (k[0] ? 8'hff : 8'h07);
                sel = {id, 24'($random(seed))};
                raw = {$random(seed), $random(seed), $random(seed), $random(seed)};
                if (id == `ID_ITLB) raw[55:53] = k[2:0];
                access(OP_SELECT, sel, `TOP_PRIV, raw, k % 4, rd, und);
                check("select undef", 64'(und), 64'h0);
                ew = exp_words(id, raw);
                for (int r = 1; r < 7; r++) begin
                    access(sreg_op_t'(r), $random(seed), `TOP_PRIV, ~raw, 0, rd, und);
                    check("readout word", rd, (r == 1) ? ew.w0 : (r == 2) ? ew.w1 : 64'h0);
                end
                // refused access below top level, select among them
                access(sreg_op_t'(k[2:0]), {~id, 24'($random(seed))}, 2'(k % 3), ~raw, 0, rd, und);
                check("refused undef", 64'(und), 64'h1);
                check("refused data", rd, 64'h0);
                // stray array answer while idle must not disturb the words
                @(posedge clk_i);
                #1;
                ram_rsp_i.valid = 1'b1;
                @(posedge clk_i);
                #1;
                ram_rsp_i.valid = 1'b0;
                access(OP_RD_I0, 32'h0, `TOP_PRIV, raw, 0, rd, und);
                check("stable word 0", rd, ew.w0);
            end
        end
        access(sreg_op_t'(3'b111), 32'h0, `TOP_PRIV, raw, 0, rd, und);
        check("unused op data", rd, 64'h0);
        check("unused op undef", 64'(und), 64'h0);
        finish_test();
    end
endmodule : test_ram_debug_readout
`default_nettype wire
